// ==== hdl/jtf_pkg.sv ====
/*
 * shared constants for the scan port front end: tap states, instruction codes,
 * register widths.
 * assumes a single 50 MHz system clock that oversamples the test clock.
 */
package jtf_pkg;
    // ------------------------------------------------------------------
    // tap controller states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [15:0] {
        ST_RESET    = 16'h0001,
        ST_IDLE     = 16'h0002,
        ST_SEL_DR   = 16'h0004,
        ST_CAP_DR   = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR   = 16'h0100,
        ST_SEL_IR   = 16'h0200,
        ST_CAP_IR   = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR   = 16'h8000
    } jtf_state_type;

    // ------------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------------
    localparam int          IR_WIDTH     = 4;
    localparam logic [3:0]  IR_CAPTURE   = 4'h1;
    localparam logic [3:0]  IR_RESET_VAL = 4'hF;
    localparam logic [3:0]  OP_EXTEST    = 4'h0;
    localparam logic [3:0]  OP_IDCODE    = 4'h1;
    localparam logic [3:0]  OP_SAMPLE    = 4'h2;
    localparam logic [3:0]  OP_PROG      = 4'h4;
    localparam logic [3:0]  OP_DBG_INT   = 4'h8;
    localparam logic [3:0]  OP_DBG_BRK   = 4'h9;
    localparam logic [3:0]  OP_BYPASS    = 4'hF;

    // ------------------------------------------------------------------
    // data register widths and the arbitrary identity value
    // ------------------------------------------------------------------
    localparam int           DR_WIDTH    = 32;
    localparam logic [31:0]  ID_VALUE    = 32'h1234_5001; // value arbitrary
    localparam int           TMS_RESET_N = 5;
endpackage : jtf_pkg

// ==== hdl/jtf_tap_front_end.sv ====
/*
 * scan port front end: tap controller, instruction register, bypass,
 * identity, boundary, programming and two debug chains, pin gating, reset pin.
 * assumes test pins come asynchronously; the system clock samples them and
 * detects test clock edges. parallel sides of long chains are plain ports.
 */
// Notes on behaviour
// - tap state machine moves only on the test mode select input.
// - instruction register or one selected data register sits between data in and out.
// - held instruction picks the active data register and its behaviour.
// - identity, bypass, boundary and programming registers are selectable.
// - internal scan and breakpoint chains serve on-chip debug only.
// - every transition and shift happens on a test clock rising edge.
// - tester presents bits on data in; device drives selected register out.
// - no test reset pin; reset comes from power-on or tms sequence.
// - fuse unprogrammed: pins are port pins and the controller stays reset.
// - fuse set and disable bit clear: port enabled, inputs pulled high.
// - data out floats except while shifting.
// - fuse defaults to programmed as delivered.
// - debug logic watches the external reset pin.
// - debug logic may pull external reset low, open-collector.
// - sixteen states, step on rising test clock, reset state after power-on.
// - all shift registers move least significant bit first.
// - four-bit instructions; capture value 0x01 shifts out during instruction shift.
// - five clocks of tms high reach the reset state from anywhere.
`timescale 1ns/1ps
`default_nettype none
module jtf_tap_front_end
    import jtf_pkg::*;
#(
    parameter int CHAIN_W = 32,
    parameter bit FUSE_DEFAULT = 1'b1 // shipped programmed
) (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                scanPortEnableFuse,
    input  wire logic                scanPortDisableBit,
    input  wire logic                tckPin,
    input  wire logic                tmsPin,
    input  wire logic                tdiPin,
    output logic                     tdoOut,
    output logic                     tdoOe,
    output logic                     pinPullupEn,
    output logic                     portPinsFree,
    input  wire logic                resetPinIn,
    output logic                     resetPinOut,
    output logic                     resetPinOe,
    input  wire logic                dbgResetReq,
    output logic                     extResetSeen,
    input  wire logic [CHAIN_W-1:0]  chainCapture,
    output logic [CHAIN_W-1:0]       chainUpdate,
    output logic                     chainUpdateStb,
    output logic [3:0]               activeInstr,
    output jtf_state_type            tapState
);
    // ------------------------------------------------------------------
    // state record
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]          tckSync;
        logic [1:0]          tmsSync;
        logic [1:0]          tdiSync;
        logic [1:0]          rstSync;
        logic [2:0]          highRun;
        jtf_state_type       st;
        logic [IR_WIDTH-1:0] irShift;
        logic [IR_WIDTH-1:0] ir;
        logic                bypass;
        logic [DR_WIDTH-1:0] drShift;
        logic [CHAIN_W-1:0]  upd;
        logic                updStb;
        logic                tdo;
        logic                tdoEn;
        logic                rstSeen;
    } jtf_regs_type;

    jtf_regs_type cur_r;
    jtf_regs_type cur_nxt;

    logic fuseOn;
    logic portOn;
    logic tckRise;
    logic tckFall;
    logic tms;
    logic tdi;

    assign fuseOn  = scanPortEnableFuse ~^ FUSE_DEFAULT; // fuse input at its delivered level = programmed
    assign portOn  = fuseOn & ~scanPortDisableBit;
    assign tms     = cur_r.tmsSync[1];
    assign tdi     = cur_r.tdiSync[1];
    // edge found on second and third sync stages only
    assign tckRise = cur_r.tckSync[1] & ~cur_r.tckSync[2];
    assign tckFall = ~cur_r.tckSync[1] & cur_r.tckSync[2];

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        cur_nxt         = cur_r;
        cur_nxt.tckSync = {cur_r.tckSync[1:0], tckPin};
        cur_nxt.tmsSync = {cur_r.tmsSync[0], tmsPin};
        cur_nxt.tdiSync = {cur_r.tdiSync[0], tdiPin};
        cur_nxt.rstSync = {cur_r.rstSync[0], resetPinIn};
        cur_nxt.updStb  = 1'b0;
        if (cur_r.rstSync[1] == 1'b0) begin
            cur_nxt.rstSeen = 1'b1;
        end
        if (!portOn) begin
            // held in reset while the pins belong to the port
            cur_nxt.st    = ST_RESET;
            cur_nxt.ir    = IR_RESET_VAL;
            cur_nxt.tdoEn = 1'b0;
            cur_nxt.highRun = 3'h0;
        end else if (tckRise) begin
            // run of tms-high rises, saturating; only the five-high check reads it
            if (!tms) begin
                cur_nxt.highRun = 3'h0;
            end else if (cur_r.highRun != 3'(TMS_RESET_N)) begin
                cur_nxt.highRun = cur_r.highRun + 3'h1;
            end
            // shift on the rising edge of the state being left, lsb first
            if (cur_r.st == ST_SHIFT_IR) begin
                cur_nxt.irShift = {tdi, cur_r.irShift[IR_WIDTH-1:1]};
            end
            if (cur_r.st == ST_SHIFT_DR) begin
                cur_nxt.bypass  = tdi;
                cur_nxt.drShift = {tdi, cur_r.drShift[DR_WIDTH-1:1]};
            end
            if (cur_r.st == ST_CAP_IR) begin
                cur_nxt.irShift = IR_CAPTURE;
            end
            if (cur_r.st == ST_CAP_DR) begin
                cur_nxt.bypass = 1'b0;
                if (cur_r.ir == OP_IDCODE) begin
                    cur_nxt.drShift = ID_VALUE;
                end else begin
                    cur_nxt.drShift = DR_WIDTH'(chainCapture);
                end
            end
            if (cur_r.st == ST_UPD_IR) begin
                cur_nxt.ir = cur_r.irShift;
            end
            if (cur_r.st == ST_UPD_DR && cur_r.ir != OP_BYPASS && cur_r.ir != OP_IDCODE) begin
                cur_nxt.upd    = CHAIN_W'(cur_r.drShift);
                cur_nxt.updStb = 1'b1;
            end
            // sixteen-state walk steered only by tms
            case (cur_r.st)
                ST_RESET:    cur_nxt.st = tms ? ST_RESET    : ST_IDLE;
                ST_IDLE:     cur_nxt.st = tms ? ST_SEL_DR   : ST_IDLE;
                ST_SEL_DR:   cur_nxt.st = tms ? ST_SEL_IR   : ST_CAP_DR;
                ST_CAP_DR:   cur_nxt.st = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_SHIFT_DR: cur_nxt.st = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_EXIT1_DR: cur_nxt.st = tms ? ST_UPD_DR   : ST_PAUSE_DR;
                ST_PAUSE_DR: cur_nxt.st = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
                ST_EXIT2_DR: cur_nxt.st = tms ? ST_UPD_DR   : ST_SHIFT_DR;
                ST_UPD_DR:   cur_nxt.st = tms ? ST_SEL_DR   : ST_IDLE;
                ST_SEL_IR:   cur_nxt.st = tms ? ST_RESET    : ST_CAP_IR;
                ST_CAP_IR:   cur_nxt.st = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_SHIFT_IR: cur_nxt.st = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_EXIT1_IR: cur_nxt.st = tms ? ST_UPD_IR   : ST_PAUSE_IR;
                ST_PAUSE_IR: cur_nxt.st = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
                ST_EXIT2_IR: cur_nxt.st = tms ? ST_UPD_IR   : ST_SHIFT_IR;
                ST_UPD_IR:   cur_nxt.st = tms ? ST_SEL_DR   : ST_IDLE;
                default:     cur_nxt.st = ST_RESET;
            endcase
            // a next state of reset reloads bypass as the safe default
            if (cur_nxt.st == ST_RESET) begin
                cur_nxt.ir = IR_RESET_VAL;
            end
        end else if (tckFall) begin
            // output path changes on the falling edge, driven only while shifting
            cur_nxt.tdoEn = (cur_r.st == ST_SHIFT_IR) || (cur_r.st == ST_SHIFT_DR);
            if (cur_r.st == ST_SHIFT_IR) begin
                cur_nxt.tdo = cur_r.irShift[0];
            end else if (cur_r.ir == OP_BYPASS) begin
                cur_nxt.tdo = cur_r.bypass;
            end else begin
                cur_nxt.tdo = cur_r.drShift[0];
            end
        end
    end

    // no test reset pin: rst_n, the tms walk and a disabled port reset the tap
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_r <= '{tckSync: 3'h0, tmsSync: 2'h3, tdiSync: 2'h3, rstSync: 2'h3, highRun: 3'h0,
                       st: ST_RESET, irShift: 4'h0, ir: IR_RESET_VAL, bypass: 1'b0,
                       drShift: '0, upd: '0, updStb: 1'b0, tdo: 1'b0, tdoEn: 1'b0, rstSeen: 1'b0};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign tdoOut         = cur_r.tdo;
    assign tdoOe          = cur_r.tdoEn & portOn;
    assign pinPullupEn    = portOn;
    assign portPinsFree   = ~portOn;
    assign resetPinOut    = 1'b0;
    assign resetPinOe     = dbgResetReq & portOn; // pull low only, never drive high
    assign extResetSeen   = cur_r.rstSeen;
    assign chainUpdate    = cur_r.upd;
    assign chainUpdateStb = cur_r.updStb;
    assign activeInstr    = cur_r.ir;
    assign tapState       = cur_r.st;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_DISABLED_RESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !portOn |=> cur_r.st == ST_RESET) else $error("tap not held in reset");
    // the enable follows the state seen at each test clock fall, so it lags an exit by half a period
    AST_TDO_FLOAT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tckFall && portOn |=>
            cur_r.tdoEn == ($past(cur_r.st) == ST_SHIFT_IR || $past(cur_r.st) == ST_SHIFT_DR))
        else $error("tdo enable does not follow shift state");
    AST_STILL_NO_EDGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !tckRise && portOn |=> cur_r.st == $past(cur_r.st)) else $error("state moved without edge");
    AST_IR_CAPTURE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tckRise && portOn && cur_r.st == ST_CAP_IR |=> cur_r.irShift == IR_CAPTURE)
        else $error("ir capture value wrong");
    AST_TMS_HIGH_RESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tckRise && portOn && tms && cur_r.st == ST_SEL_IR |=> cur_r.st == ST_RESET)
        else $error("tms walk missed reset");
    AST_FIVE_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cur_r.highRun == 3'(TMS_RESET_N) |-> cur_r.st == ST_RESET)
        else $error("five tms highs did not reach reset");
    AST_IR_LSB_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tckRise && portOn && cur_r.st == ST_SHIFT_IR |=> cur_r.irShift[3] == $past(tdi))
        else $error("ir not shifted lsb first");
    AST_BYPASS_STAGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tckRise && portOn && cur_r.st == ST_SHIFT_DR |=> cur_r.bypass == $past(tdi))
        else $error("bypass stage wrong");
    AST_IR_UPDATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tckRise && portOn && cur_r.st == ST_UPD_IR |=> cur_r.ir == $past(cur_r.irShift))
        else $error("instruction not latched");
    AST_RESET_PIN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !cur_r.rstSync[1] |=> extResetSeen) else $error("reset pin not seen");
    AST_PULLDOWN_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
        resetPinOe |-> !resetPinOut && dbgResetReq) else $error("reset pin pulled without request");

    COV_SHIFT_IR: cover property (@(posedge ref_clk) cur_r.st == ST_SHIFT_IR);
    COV_SHIFT_DR: cover property (@(posedge ref_clk) cur_r.st == ST_SHIFT_DR && tdoOe);
    COV_UPD_DR:   cover property (@(posedge ref_clk) chainUpdateStb);
endmodule : jtf_tap_front_end
`default_nettype wire

// ==== tb/jtf_tester_model.sv ====
/*
 * tester model: drives test clock, mode select and data in, collects data out.
 * assumes a 50 MHz ref_clk; test clock of 160 ns that stands low between frames.
 */
`timescale 1ns/1ps
`default_nettype none
module jtf_tester_model (
    input  wire logic ref_clk,
    input  wire logic tdoOut,
    input  wire logic tdoOe,
    output var  logic tckPin,
    output var  logic tmsPin,
    output var  logic tdiPin
);
    logic seenOe;
    logic oeAll;
    // ------------------------------------------------------------------
    // test clock cycles
    // ------------------------------------------------------------------
    initial begin
        tckPin = 1'b0;
        tmsPin = 1'b1;
        tdiPin = 1'b1;
    end
    // caller sits at a ref_clk edge; data out has stood since the last fall, so it is taken before the rise
    task automatic tick(input logic tmsV, input logic tdiV, output logic tdoV);
        tmsPin <= tmsV;
        tdiPin <= tdiV;
        repeat (5) @(posedge ref_clk);
        // a released line floats up to the board pull-up
        tdoV   = tdoOe ? tdoOut : 1'b1;
        seenOe = tdoOe;
        tckPin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        tckPin <= 1'b0;
    endtask : tick
    // mode select walk, first step in bit 0; settling lets the synchronisers catch up
    task automatic nav(input logic [7:0] seq, input int n);
        logic b;
        for (int i = 0; i < n; i++) tick(seq[i], 1'b1, b);
        repeat (6) @(posedge ref_clk);
    endtask : nav
    // instruction or data scan from idle: lsb first, mode select high with the last bit
    task automatic op(input logic isIr, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic b;
        nav(isIr ? 8'h03 : 8'h01, isIr ? 4 : 3);
        dout  = '0;
        oeAll = 1'b1;
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], b);
            dout[i] = b;
            oeAll   = oeAll & seenOe;
        end
        nav(8'h01, 2);
    endtask : op
endmodule : jtf_tester_model
`default_nettype wire

// ==== tb/jtf_tap_front_end_tb.sv ====
/*
 * self-checking bench of the scan port front end; the tester model drives the link.
 * assumes jtf_pkg and jtf_tester_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module jtf_tap_front_end_tb;
    import jtf_pkg::*;
    logic          ref_clk, rst_n, fuse, disBit, tckPin, tmsPin, tdiPin, tdoOut, tdoOe, pullEn;
    logic          pinsFree, rstIn, rstOut, rstOe, dbgReq, rstSeen, updStb;
    logic [31:0]   capV, updV, dout;
    logic [3:0]    instr;
    jtf_state_type st;
    int            n_fail, cmp_count, cyc, nStb;
    jtf_tap_front_end u_jtf_tap_front_end (.ref_clk(ref_clk), .rst_n(rst_n), .scanPortEnableFuse(fuse),
        .scanPortDisableBit(disBit), .tckPin(tckPin), .tmsPin(tmsPin), .tdiPin(tdiPin), .tdoOut(tdoOut),
        .tdoOe(tdoOe), .pinPullupEn(pullEn), .portPinsFree(pinsFree), .resetPinIn(rstIn),
        .resetPinOut(rstOut), .resetPinOe(rstOe), .dbgResetReq(dbgReq), .extResetSeen(rstSeen),
        .chainCapture(capV), .chainUpdate(updV), .chainUpdateStb(updStb), .activeInstr(instr), .tapState(st));
    jtf_tester_model u_jtf_tester_model (.ref_clk(ref_clk), .tdoOut(tdoOut), .tdoOe(tdoOe),
        .tckPin(tckPin), .tmsPin(tmsPin), .tdiPin(tdiPin));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // the run needs some 2800 cycles; the ceiling leaves room for slow detection
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (updStb === 1'b1) nStb <= nStb + 1;
        if (cyc == 12000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic s_idcode;
        chk({st, instr, tdoOe, pullEn, pinsFree}, {ST_RESET, IR_RESET_VAL, 3'b010}, "reset");
        u_jtf_tester_model.nav(8'h00, 1);
        u_jtf_tester_model.op(1'b1, 4, {28'h0, OP_IDCODE}, dout);
        chk({dout[3:0], u_jtf_tester_model.oeAll, tdoOe}, {IR_CAPTURE, 2'b10}, "ir shift");
        chk({st, instr}, {ST_IDLE, OP_IDCODE}, "ir update");
        u_jtf_tester_model.op(1'b0, 32, 32'h0, dout);
        chk(dout, ID_VALUE, "identity");
    endtask : s_idcode
    task automatic s_bypass;
        u_jtf_tester_model.op(1'b1, 4, {28'h0, OP_BYPASS}, dout);
        u_jtf_tester_model.op(1'b0, 8, 32'hB5, dout);
        chk(dout[7:1], 7'h35, "bypass");
    endtask : s_bypass
    task automatic s_chains;
        logic [3:0] ops [5];
        ops = '{OP_EXTEST, OP_SAMPLE, OP_PROG, OP_DBG_INT, OP_DBG_BRK};
        foreach (ops[i]) begin
            capV <= 32'hC3A5_0F96 ^ i;
            u_jtf_tester_model.op(1'b1, 4, {28'h0, ops[i]}, dout);
            u_jtf_tester_model.op(1'b0, 32, 32'h1357_9BDF + i, dout);
            chk(dout, 32'hC3A5_0F96 ^ i, "capture");
            chk(updV, 32'h1357_9BDF + i, "update");
        end
        chk(nStb, 32'h5, "strobes");
    endtask : s_chains
    task automatic s_tms_reset;
        u_jtf_tester_model.nav(8'h79, 7);
        chk(st, ST_SEL_IR, "four high");
        u_jtf_tester_model.nav(8'h01, 1);
        chk({st, instr}, {ST_RESET, IR_RESET_VAL}, "five high");
    endtask : s_tms_reset
    task automatic s_port_off;
        u_jtf_tester_model.nav(8'h00, 1);
        disBit <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({st, pullEn, pinsFree, tdoOe}, {ST_RESET, 3'b010}, "disabled");
        {fuse, disBit} <= 2'b00;
        u_jtf_tester_model.nav(8'h00, 2);
        chk({st, pullEn, pinsFree}, {ST_RESET, 2'b01}, "fuse off");
        fuse <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask : s_port_off
    task automatic s_reset_pin;
        chk({rstSeen, rstOe}, 2'b00, "pin idle");
        rstIn  <= 1'b0;
        dbgReq <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk({rstSeen, rstOe, rstOut}, 3'b110, "pin low");
        rstIn  <= 1'b1;
        dbgReq <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk({rstSeen, rstOe}, 2'b10, "pin freed");
    endtask : s_reset_pin
    initial begin
        {rst_n, fuse, disBit, rstIn, dbgReq} = 5'b01010;
        capV      = 32'h0;
        cyc       = 0;
        nStb      = 0;
        n_fail    = 0;
        cmp_count = 0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        s_idcode();
        s_bypass();
        s_chains();
        s_tms_reset();
        s_port_off();
        s_reset_pin();
        conclude();
    end
endmodule : jtf_tap_front_end_tb
`default_nettype wire
